// *** verilog/atc_pkg.sv ***
// Purpose: shared constants and carrier types for acquisition trigger control
// Assumes: single clock domain, all counts in clock cycles
// Notes:   acquisition mode codes other than single and continuous are illegal
package atc_pkg;

   localparam int ATC_CNT_W      = 24;
   localparam int ATC_BURST_W    = 16;
   localparam int ATC_SYNC_DEPTH = 2;

   localparam logic [1:0] ATC_MODE_SINGLE     = 2'h1;
   localparam logic [1:0] ATC_MODE_CONTINUOUS = 2'h2;

   localparam logic ATC_STD_MODE_RESET = 1'h0;

   localparam logic [ATC_CNT_W-1:0]   ATC_CNT_ONE   = 24'h000001;
   localparam logic [ATC_CNT_W-1:0]   ATC_CNT_ZERO  = 24'h000000;
   localparam logic [ATC_CNT_W-1:0]   ATC_CNT_FULL  = 24'hFFFFFF;
   localparam logic [ATC_BURST_W-1:0] ATC_BURST_ONE = 16'h0001;
   localparam logic [ATC_BURST_W-1:0] ATC_BURST_ZERO = 16'h0000;

   typedef enum logic [1:0] {
      ATC_IDLE       = 2'b00,
      ATC_WAIT_ACQ   = 2'b01,
      ATC_WAIT_FRAME = 2'b11,
      ATC_EXPOSE     = 2'b10
   } atc_state_t;

   typedef struct packed {
      logic                   acqTrigEnable;
      logic                   acqTrigFromLine1;
      logic                   acqTrigRising;
      logic                   frameTrigEnable;
      logic                   frameTrigFromLine1;
      logic                   frameTrigRising;
      logic [1:0]             acqMode;
      logic                   frame_rate_limit_enable;
      logic [ATC_CNT_W-1:0]   framePeriod;
      logic [ATC_CNT_W-1:0]   minFramePeriod;
      logic [ATC_CNT_W-1:0]   exposureTime;
      logic [ATC_BURST_W-1:0] framesPerBurst;
   } atc_cfg_t;

   typedef struct packed {
      atc_state_t             state;
      logic                   standardMode;
      logic                   waitAcqTrig;
      logic                   waitFrameTrig;
      logic                   exposureActive;
      logic [ATC_BURST_W-1:0] burstCount;
   } atc_status_t;

endpackage

// *** verilog/atc_edge_sync.sv ***
// Purpose: bring an asynchronous pin into the clock domain and find its edges
// Assumes: pin is stable for at least two clock periods between edges
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module atc_edge_sync
   import atc_pkg::*;
#(
   parameter int DEPTH = ATC_SYNC_DEPTH
) (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic pinIn,
   output logic      risePulse,
   output logic      fallPulse
);

   logic [DEPTH-1:0] sync_reg;
   logic [DEPTH-1:0] sync_next;
   logic             last_reg;
   logic             rise_reg;
   logic             fall_reg;
   logic             rise_next;
   logic             fall_next;

   always_comb begin
      sync_next = {sync_reg[DEPTH-2:0], pinIn};
      rise_next = sync_reg[DEPTH-1] & ~last_reg;
      fall_next = ~sync_reg[DEPTH-1] & last_reg;
   end

   // edge is taken against the last settled stage only
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync_reg <= '0;
         last_reg <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end else begin
         sync_reg <= sync_next;
         last_reg <= sync_reg[DEPTH-1];
         rise_reg <= rise_next;
         fall_reg <= fall_next;
      end
   end

   assign risePulse = rise_reg;
   assign fallPulse = fall_reg;

endmodule

// *** verilog/atc_top.sv ***
// Purpose: acquisition sequencer with acquisition-start and frame-start
//          triggering, burst counting and internal frame-rate generation
// Assumes: command strobes and configuration come from the clock domain;
//          the maximum-rate period is computed outside and given as cycles
// Notes:   one frame is accepted per trigger; exposure ends the frame here
//
// Functional notes
// - acquisition-start trigger comes from line 1 when enabled and selected
// - line 1 acquisition-start edge is rising or falling per setting
// - with acquisition trigger on, wait for it and ignore frame triggers
// - qualifying acquisition edge moves to waiting for frame triggers
// - count accepted frames; at frames-per-burst return to acquisition wait
// - each new acquisition edge in acquisition wait starts a new burst
// - frame behaviour only in standard mode; legacy mode after reset
// - in frame wait, each frame trigger starts one frame
// - frame wait needs valid mode, start command, and trigger if enabled
// - frame trigger mode off means all frame triggers are internal
// - off and single-frame: one internal trigger per start command
// - off and continuous: internal triggers repeat until stop command
// - rate limit disabled: internal triggers at the maximum rate
// - limit enabled and below maximum: internal triggers at programmed rate
// - limit enabled and above maximum: clamp to maximum rate
// - frame triggers outside frame wait are ignored
// - frame trigger off: exposure length is the programmed exposure time
// - external frame triggers come from line 1 only when frameTrigFromLine1 selects it
// - line 1 frame trigger edge is rising or falling per setting
`timescale 1ns/1ps
module atc_top
   import atc_pkg::*;
#(
   parameter int CNT_W   = ATC_CNT_W,
   parameter int BURST_W = ATC_BURST_W
) (
   input  wire logic  clock,
   input  wire logic  reset_n,
   input  wire logic  line1In,
   input  atc_cfg_t   cfg,
   input  wire logic  modeSelWrite,
   input  wire logic  modeSelStandard,
   input  wire logic  acqStartCmd,
   input  wire logic  acqStopCmd,
   output logic       frameStartPulse,
   output logic       ext_acq_start_pulse,
   output atc_status_t status
);

   logic line1Rise;
   logic line1Fall;

   atc_edge_sync #(
      .DEPTH (ATC_SYNC_DEPTH)
   ) u_line1 (
      .clock     (clock),
      .reset_n   (reset_n),
      .pinIn     (line1In),
      .risePulse (line1Rise),
      .fallPulse (line1Fall)
   );

   atc_state_t         state_reg;
   atc_state_t         state_next;
   logic               stdMode_reg;
   logic               stdMode_next;
   logic [CNT_W-1:0]   period_reg;
   logic [CNT_W-1:0]   period_next;
   logic [CNT_W-1:0]   expCnt_reg;
   logic [CNT_W-1:0]   expCnt_next;
   logic [BURST_W-1:0] burst_reg;
   logic [BURST_W-1:0] burst_next;
   logic               frameStart_reg;
   logic               frameStart_next;
   logic               acqEdge_reg;
   logic               acqEdge_next;

   logic               modeValid;
   logic               continuous;
   logic               acqEdge;
   logic               extFrameEdge;
   logic [CNT_W-1:0]   effPeriod;
   logic [CNT_W-1:0]   expLoad;
   logic               intFrameTrig;
   logic               frameTrig;
   logic               burstDone;

   // mode selection: comes up in the legacy scheme
   always_comb begin
      stdMode_next = stdMode_reg;
      if (modeSelWrite) begin
         stdMode_next = modeSelStandard;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stdMode_reg <= ATC_STD_MODE_RESET;
      end else begin
         stdMode_reg <= stdMode_next;
      end
   end

   // trigger qualification
   always_comb begin
      modeValid  = (cfg.acqMode == ATC_MODE_SINGLE) ||
                   (cfg.acqMode == ATC_MODE_CONTINUOUS);
      continuous = (cfg.acqMode == ATC_MODE_CONTINUOUS);
      // line 1 as acquisition source, edge as selected
      acqEdge = cfg.acqTrigEnable && cfg.acqTrigFromLine1 &&
                (cfg.acqTrigRising ? line1Rise : line1Fall);
      // line 1 as frame source, edge as selected
      extFrameEdge = cfg.frameTrigEnable && cfg.frameTrigFromLine1 &&
                     (cfg.frameTrigRising ? line1Rise : line1Fall);
      // with the limit enabled, the slower of programmed and maximum rate wins
      if (cfg.frame_rate_limit_enable &&
          (cfg.framePeriod > cfg.minFramePeriod)) begin
         effPeriod = cfg.framePeriod;
      end else begin
         effPeriod = cfg.minFramePeriod;
      end
      if (effPeriod == ATC_CNT_ZERO) begin
         effPeriod = ATC_CNT_ONE;
      end
      // exposure length from the programmed setting
      expLoad = (cfg.exposureTime == ATC_CNT_ZERO) ? ATC_CNT_ONE :
                cfg.exposureTime;
      // internal generation only when frame triggering is off
      intFrameTrig = !cfg.frameTrigEnable && (period_reg >= effPeriod);
      frameTrig    = cfg.frameTrigEnable ? extFrameEdge : intFrameTrig;
      burstDone    = cfg.acqTrigEnable &&
                     (burst_reg == cfg.framesPerBurst);
   end

   // sequencer
   always_comb begin
      state_next      = state_reg;
      period_next     = period_reg;
      expCnt_next     = expCnt_reg;
      burst_next      = burst_reg;
      frameStart_next = 1'b0;
      acqEdge_next    = 1'b0;
      if (period_reg != ATC_CNT_FULL) begin
         period_next = period_reg + ATC_CNT_ONE;
      end
      if (!stdMode_reg) begin
         // legacy scheme: this sequencer stays parked
         state_next = ATC_IDLE;
         burst_next = ATC_BURST_ZERO;
      end else if (acqStopCmd) begin
         state_next = ATC_IDLE;
         burst_next = ATC_BURST_ZERO;
      end else begin
         unique case (state_reg)
            ATC_IDLE: begin
               // start only with a valid mode
               if (acqStartCmd && modeValid) begin
                  burst_next = ATC_BURST_ZERO;
                  // first internal trigger fires at once
                  period_next = ATC_CNT_FULL;
                  if (cfg.acqTrigEnable) begin
                     state_next = ATC_WAIT_ACQ;
                  end else begin
                     state_next = ATC_WAIT_FRAME;
                  end
               end
            end
            ATC_WAIT_ACQ: begin
               // frame triggers ignored here
               if (acqEdge) begin
                  acqEdge_next = 1'b1;
                  burst_next   = ATC_BURST_ZERO;
                  period_next  = ATC_CNT_FULL;
                  state_next   = ATC_WAIT_FRAME;
               end else if (!cfg.acqTrigEnable) begin
                  // trigger switched off while waiting: nothing to wait for
                  state_next = ATC_WAIT_FRAME;
               end
            end
            ATC_WAIT_FRAME: begin
               if (frameTrig) begin
                  frameStart_next = 1'b1;
                  period_next     = ATC_CNT_ONE;
                  expCnt_next     = expLoad;
                  burst_next      = burst_reg + ATC_BURST_ONE;
                  state_next      = ATC_EXPOSE;
               end
            end
            ATC_EXPOSE: begin
               // triggers during exposure are dropped
               if (expCnt_reg > ATC_CNT_ONE) begin
                  expCnt_next = expCnt_reg - ATC_CNT_ONE;
               end else begin
                  expCnt_next = ATC_CNT_ZERO;
                  if (!continuous) begin
                     state_next = ATC_IDLE; // single frame ends
                  end else if (burstDone) begin
                     burst_next = ATC_BURST_ZERO;
                     state_next = ATC_WAIT_ACQ;
                  end else begin
                     state_next = ATC_WAIT_FRAME; // until stop
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_reg      <= ATC_IDLE;
         period_reg     <= ATC_CNT_ZERO;
         expCnt_reg     <= ATC_CNT_ZERO;
         burst_reg      <= ATC_BURST_ZERO;
         frameStart_reg <= 1'b0;
         acqEdge_reg    <= 1'b0;
      end else begin
         state_reg      <= state_next;
         period_reg     <= period_next;
         expCnt_reg     <= expCnt_next;
         burst_reg      <= burst_next;
         frameStart_reg <= frameStart_next;
         acqEdge_reg    <= acqEdge_next;
      end
   end

   assign frameStartPulse     = frameStart_reg;
   assign ext_acq_start_pulse = acqEdge_reg;

   always_comb begin
      status.state          = state_reg;
      status.standardMode   = stdMode_reg;
      status.waitAcqTrig    = (state_reg == ATC_WAIT_ACQ);
      status.waitFrameTrig  = (state_reg == ATC_WAIT_FRAME);
      status.exposureActive = (state_reg == ATC_EXPOSE);
      status.burstCount     = burst_reg;
   end

endmodule

// *** testbench/atc_top_sva.sv ***
// Purpose: port-level assertions for the acquisition sequencer
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes:   configuration is held static by the bench during commands
`timescale 1ns/1ps
module atc_top_sva
   import atc_pkg::*;
(
   input wire logic  clock,
   input wire logic  reset_n,
   input wire logic  line1In,
   input atc_cfg_t   cfg,
   input wire logic  acqStartCmd,
   input wire logic  acqStopCmd,
   input wire logic  frameStartPulse,
   input wire logic  ext_acq_start_pulse,
   input atc_status_t status
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   wire logic modeOk = cfg.acqMode == ATC_MODE_SINGLE ||
                       cfg.acqMode == ATC_MODE_CONTINUOUS;
   wire logic idle = status.state == ATC_IDLE;

   AST_STOP: assert property (
      acqStopCmd |=> idle && status.burstCount == ATC_BURST_ZERO)
      else $error("stop left sequencer busy");
   AST_LEGACY: assert property (
      !status.standardMode && idle |=> idle)
      else $error("sequencer left idle in legacy scheme");
   AST_START: assert property (
      acqStartCmd && !acqStopCmd && status.standardMode && idle && modeOk
      |=> status.state == (cfg.acqTrigEnable ? ATC_WAIT_ACQ : ATC_WAIT_FRAME))
      else $error("start went to wrong state");
   AST_BADMODE: assert property (
      acqStartCmd && idle && !modeOk |=> idle)
      else $error("start accepted with invalid mode");
   AST_NOFRAME: assert property (
      status.state == ATC_WAIT_ACQ |=> !frameStartPulse)
      else $error("frame started while awaiting acquisition trigger");
   AST_INWAIT: assert property (
      frameStartPulse |-> $past(status.state) == ATC_WAIT_FRAME &&
      !$past(frameStartPulse))
      else $error("frame started outside frame wait");
   AST_ACQPULSE: assert property (
      ext_acq_start_pulse && !$past(acqStopCmd) |->
      status.waitFrameTrig && $past(status.state) == ATC_WAIT_ACQ)
      else $error("acquisition pulse without state move");
   AST_LINEACQ: assert property (
      cfg.acqTrigEnable && cfg.acqTrigFromLine1 && status.state == ATC_WAIT_ACQ
      && (cfg.acqTrigRising ? $rose(line1In) : $fell(line1In))
      |-> ##[2:5] ext_acq_start_pulse)
      else $error("line edge did not start acquisition");
   AST_LINEFRAME: assert property (
      cfg.frameTrigEnable && cfg.frameTrigFromLine1 &&
      status.state == ATC_WAIT_FRAME &&
      (cfg.frameTrigRising ? $rose(line1In) : $fell(line1In))
      |-> ##[2:5] frameStartPulse)
      else $error("line edge did not start a frame");
   CVR_ACQ: cover property (ext_acq_start_pulse);
   CVR_EXT: cover property (frameStartPulse && cfg.frameTrigEnable);
   CVR_STOP: cover property (acqStopCmd && status.state == ATC_EXPOSE);
endmodule

bind atc_top atc_top_sva u_sva (.clock(clock), .reset_n(reset_n),
   .line1In(line1In), .cfg(cfg), .acqStartCmd(acqStartCmd),
   .acqStopCmd(acqStopCmd), .frameStartPulse(frameStartPulse),
   .ext_acq_start_pulse(ext_acq_start_pulse), .status(status));

// *** testbench/atc_line_src.sv ***
// Purpose: external trigger source on input line 1
// Assumes: caller sits just after a falling clock edge
// Notes:   every level is held far beyond the two-cycle minimum
`timescale 1ns/1ps
module atc_line_src (
   input  wire logic clock,
   output logic      line1
);
   initial line1 = 1'b0;
   task automatic drive(input logic lvl, input int hold);
      @(negedge clock);
      line1 = lvl;
      repeat (hold) @(negedge clock);
   endtask
endmodule

// *** testbench/testbench.sv ***
// Purpose: directed tests of the acquisition sequencer
// Assumes: inputs change at the falling edge only
// Notes:   frame gaps and exposure lengths are measured in cycles
`timescale 1ns/1ps
module testbench;
   import atc_pkg::*;
   logic        clock = 1'b0;
   logic        reset_n, modeSelWrite, modeSelStandard;
   logic        acqStartCmd, acqStopCmd, frameStartPulse, ext_acq_start_pulse;
   wire logic   line1In;
   atc_cfg_t    cfg;
   atc_status_t status;
   int          mismatches = 0, testsRun = 0, cycles = 0, n;
   int          fsCnt = 0, asCnt = 0, gapCnt = 0, lastGap = 0;
   int          expRun = 0, expLen = 0;

   always #2 clock = ~clock;
   atc_line_src src (.clock(clock), .line1(line1In));
   atc_top uut (.clock(clock), .reset_n(reset_n), .line1In(line1In),
      .cfg(cfg), .modeSelWrite(modeSelWrite),
      .modeSelStandard(modeSelStandard), .acqStartCmd(acqStartCmd),
      .acqStopCmd(acqStopCmd), .frameStartPulse(frameStartPulse),
      .ext_acq_start_pulse(ext_acq_start_pulse), .status(status));

   task automatic tallyAndFinish;
      if (mismatches == 0 && testsRun > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clock);
   endtask
   task automatic cmd(input logic stop);
      if (stop) acqStopCmd = 1'b1; else acqStartCmd = 1'b1;
      cyc(1);
      // drop only the strobe raised here, so a following call may raise
      // the other one in this same step without a double assignment
      if (stop) acqStopCmd = 1'b0; else acqStartCmd = 1'b0;
   endtask
   task automatic run_rate(input logic lim, input logic [23:0] per,
                           input int gap);
      cfg.frame_rate_limit_enable = lim;
      cfg.framePeriod = per;
      cmd(1'b0);
      cyc(3 * gap + 4);
      check(lastGap, gap);
      check(expLen, 3);
      cmd(1'b1);
      check(status.state, ATC_IDLE);
      check(status.burstCount, ATC_BURST_ZERO);
   endtask

   // sampled at the falling edge so registered outputs have settled
   always @(negedge clock) begin
      gapCnt <= frameStartPulse ? 1 : gapCnt + 1;
      if (frameStartPulse) begin
         fsCnt <= fsCnt + 1;
         lastGap <= gapCnt;
      end
      if (ext_acq_start_pulse) asCnt <= asCnt + 1;
      expRun <= status.exposureActive ? expRun + 1 : 0;
      if (!status.exposureActive && expRun != 0) expLen <= expRun;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         tallyAndFinish();
      end
   end

   initial begin
      cfg = '0;
      reset_n = 1'b0;
      modeSelWrite = 1'b0;
      modeSelStandard = 1'b0;
      acqStartCmd = 1'b0;
      acqStopCmd = 1'b0;
      cfg.minFramePeriod = 24'h00000A;
      cfg.exposureTime = 24'h000003;
      cfg.framesPerBurst = 16'h0002;
      cfg.acqMode = ATC_MODE_CONTINUOUS;
      cyc(4);
      reset_n = 1'b1;
      cyc(1);
      check(status.standardMode, ATC_STD_MODE_RESET);
      cmd(1'b0);
      cyc(20);
      check(fsCnt, 0);
      modeSelStandard = 1'b1;
      modeSelWrite = 1'b1;
      cyc(1);
      modeSelWrite = 1'b0;
      cyc(1);
      run_rate(1'b0, 24'h000014, 10);
      run_rate(1'b1, 24'h000014, 20);
      run_rate(1'b1, 24'h000005, 10);
      cfg.acqMode = ATC_MODE_SINGLE;
      n = fsCnt;
      cmd(1'b0);
      cyc(40);
      check(fsCnt - n, 1);
      check(status.state, ATC_IDLE);
      for (int m = 0; m < 4; m += 3) begin
         cfg.acqMode = m[1:0];
         cmd(1'b0);
         cyc(20);
         check(fsCnt - n, 1);
      end
      // burst gated by line 1; continuous is mandatory with the gate on
      cfg.acqMode = ATC_MODE_CONTINUOUS;
      cfg.acqTrigEnable = 1'b1;
      cfg.acqTrigFromLine1 = 1'b1;
      cfg.acqTrigRising = 1'b1;
      n = fsCnt;
      cmd(1'b0);
      cyc(30);
      check(status.waitAcqTrig, 1'b1);
      check(fsCnt - n, 0);
      src.drive(1'b1, 60);
      check(asCnt, 1);
      check(fsCnt - n, 2);
      check(status.state, ATC_WAIT_ACQ);
      check(status.burstCount, ATC_BURST_ZERO);
      src.drive(1'b0, 30);
      check(asCnt, 1);
      cfg.acqTrigRising = 1'b0;
      src.drive(1'b1, 30);
      src.drive(1'b0, 60);
      check(asCnt, 2);
      check(fsCnt - n, 4);
      cmd(1'b1);
      cfg.acqTrigEnable = 1'b0;
      cfg.frameTrigEnable = 1'b1;
      cfg.frameTrigFromLine1 = 1'b1;
      n = fsCnt;
      src.drive(1'b1, 10);
      src.drive(1'b0, 10);
      check(fsCnt - n, 0);
      cmd(1'b0);
      cyc(30);
      check(fsCnt - n, 0);
      repeat (3) begin
         src.drive(1'b1, 10);
         src.drive(1'b0, 20);
      end
      check(fsCnt - n, 3);
      check(status.state, ATC_WAIT_FRAME);
      check(status.waitFrameTrig, 1'b1);
      cmd(1'b1);
      tallyAndFinish();
   end
endmodule
